// file: hdl/aps_regs.vh
`ifndef APS_REGS_VH
`define APS_REGS_VH
// ==========================================
// register offsets (byte addresses)
`define APS_OFF_CTRL 12'h000
`define APS_OFF_STAT 12'h004
`define APS_OFF_MASK 12'h008
`define APS_OFF_SCAN 12'h00c
`define APS_OFF_TEXT0 12'h010
`define APS_OFF_TEXT1 12'h014
`define APS_OFF_DST 12'h020
`define APS_OFF_SRC 12'h040
// ==========================================
// control fields
`define APS_CTRL_DRIVE 0
`define APS_CTRL_BYTEPACK 1
`define APS_CTRL_MODE16 2
`define APS_CTRL_PACKGO 3
// status / interrupt fields
`define APS_ST_DONE 0
`define APS_ST_PACKED 1
`define APS_ST_ABORT 2
// ==========================================
// reset values and timing
`define APS_CTRL_RST 32'h0000_0000
`define APS_MASK_RST 3'h0
`define APS_SCAN_MS 1
`define APS_CLK_KHZ 50000
`define APS_SCAN_CYC (`APS_SCAN_MS * `APS_CLK_KHZ)
`define APS_SCAN_RST 24'hc350
`endif

// file: hdl/aps_scan_div.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// scan period divider, one-cycle tick
module aps_scan_div (
  input wire i_mclk,
  input wire i_rst_b,
  input wire [23:0] i_period,
  output wire o_tick
);
  reg [23:0] cnt_ff;
  wire [23:0] nxt_cnt;
  // count down, reload at one
  assign o_tick = (cnt_ff <= 24'h000001);
  assign nxt_cnt = o_tick ? i_period : cnt_ff - 24'h000001;
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      cnt_ff <= 24'h000001;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule
`default_nettype wire

// file: hdl/aps_top.v
// Summary of operation
// - pack function turns eight text letters into codes in consecutive destination words
// - selector off: two codes per word in four words, earlier letter low
// - selector on: one code per word low byte, upper byte zero, eight words
// - print reads characters from consecutive source words from the start: four in eight-char mode, eight in sixteen-char mode
// - ten print points: eight data, then scan strobe, then busy flag
// - character bit 0 on lowest data point, bit 7 on highest
// - mode off: the eight source characters go out in order
// - done flag set when sequence finishes; mode bit picks print mode
// - eight-char mode: drive falling mid-sequence aborts, all points off
// - after abort, returning drive restarts from the first character
// - mode on: up to sixteen chars, drive loss does not stop string
// - sixteen-char mode: zero byte ends string, nothing after it sent
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.vh"
module aps_top (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  output wire o_irq,
  output reg [9:0] o_print
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SEND = 2'h1;
  localparam ST_HOLD = 2'h2;

  reg [31:0] ctrl_ff;
  reg [2:0] stat_ff;
  reg [2:0] mask_ff;
  reg [23:0] scan_ff;
  reg [63:0] text_ff;
  reg [15:0] dst_ff [0:7];
  reg [15:0] src_ff [0:7];
  reg [1:0] state_ff;
  reg [3:0] idx_ff;
  reg strobe_ph_ff;
  reg [1:0] nxt_state;
  reg [3:0] nxt_idx;
  reg [9:0] nxt_print;
  reg nxt_strobe_ph;
  reg [2:0] ev;
  wire tick;
  wire wr_en;
  wire rd_en;
  wire drive;
  wire mode16;
  wire [7:0] cur_char;
  wire [3:0] last_idx;
  integer k;

  // ==========================================
  // helpers
  // byte n (0..15) of the source window, low byte of each word first
  function [7:0] src_byte;
    input [127:0] flat;
    input [3:0] n;
    begin
      src_byte = flat[{n, 3'h0} +: 8];
    end
  endfunction

  // true when addr falls inside the eight-word window that starts at base
  function win_hit;
    input [11:0] addr;
    input [11:0] base;
    begin
      win_hit = ({addr[11:5], 5'h00} == base);
    end
  endfunction

  wire [127:0] src_flat = {src_ff[7], src_ff[6], src_ff[5], src_ff[4],
                           src_ff[3], src_ff[2], src_ff[1], src_ff[0]};

  // ==========================================
  // scan divider
  aps_scan_div u_div (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_period(scan_ff),
    .o_tick(tick)
  );

  // ==========================================
  // apb decode, zero wait state
  assign o_pready = 1'b1;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_pwrite;
  assign o_pslverr = 1'b0;
  assign drive = ctrl_ff[`APS_CTRL_DRIVE];
  assign mode16 = ctrl_ff[`APS_CTRL_MODE16];
  assign o_irq = |(stat_ff & mask_ff);

  // read mux, registered data
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en && !i_penable) begin
      o_prdata <= 32'h0000_0000;
      case (i_paddr)
        `APS_OFF_CTRL: o_prdata <= {28'h0, ctrl_ff[3:0]};
        `APS_OFF_STAT: o_prdata <= {29'h0, stat_ff};
        `APS_OFF_MASK: o_prdata <= {29'h0, mask_ff};
        `APS_OFF_SCAN: o_prdata <= {8'h00, scan_ff};
        `APS_OFF_TEXT0: o_prdata <= text_ff[31:0];
        `APS_OFF_TEXT1: o_prdata <= text_ff[63:32];
        default: begin
          if (win_hit(i_paddr, `APS_OFF_DST))
            o_prdata <= {16'h0000, dst_ff[i_paddr[4:2]]};
          else if (win_hit(i_paddr, `APS_OFF_SRC))
            o_prdata <= {16'h0000, src_ff[i_paddr[4:2]]};
          else
            o_prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================
  // control, text, source and pack
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ctrl_ff <= `APS_CTRL_RST;
      mask_ff <= `APS_MASK_RST;
      scan_ff <= `APS_SCAN_RST;
      text_ff <= 64'h0;
      for (k = 0; k < 8; k = k + 1) begin
        dst_ff[k] <= 16'h0000;
        src_ff[k] <= 16'h0000;
      end
    end else begin
      ctrl_ff[`APS_CTRL_PACKGO] <= 1'b0;
      if (wr_en) begin
        case (i_paddr)
          `APS_OFF_CTRL: ctrl_ff <= {28'h0, i_pwdata[3:0]};
          `APS_OFF_MASK: mask_ff <= i_pwdata[2:0];
          `APS_OFF_SCAN: scan_ff <= i_pwdata[23:0];
          `APS_OFF_TEXT0: text_ff[31:0] <= i_pwdata;
          `APS_OFF_TEXT1: text_ff[63:32] <= i_pwdata;
          default: begin
            if (win_hit(i_paddr, `APS_OFF_SRC))
              src_ff[i_paddr[4:2]] <= i_pwdata[15:0];
          end
        endcase
      end
      // pack eight letters into destination words
      if (ctrl_ff[`APS_CTRL_PACKGO]) begin
        for (k = 0; k < 8; k = k + 1) begin
          if (ctrl_ff[`APS_CTRL_BYTEPACK])
            dst_ff[k] <= {8'h00, text_ff[k*8 +: 8]};
          else if (k < 4)
            dst_ff[k] <= text_ff[(k % 4) * 16 +: 16];
        end
      end
    end
  end

  // ==========================================
  // print sequencer
  assign cur_char = src_byte(src_flat, idx_ff);
  assign last_idx = mode16 ? 4'hf : 4'h7;

  always @* begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_print = o_print;
    nxt_strobe_ph = strobe_ph_ff;
    ev = 3'h0;
    case (state_ff)
      ST_IDLE: begin
        nxt_print = 10'h000;
        if (drive && tick) begin
          nxt_state = ST_SEND;
          nxt_idx = 4'h0;
        end
      end
      ST_SEND: begin
        if (!drive && !mode16) begin
          nxt_state = ST_IDLE;
          nxt_print = 10'h000;
          ev[`APS_ST_ABORT] = 1'b1;
        end else if (tick) begin
          if (mode16 && cur_char == 8'h00) begin
            nxt_state = ST_HOLD;
            nxt_print = 10'h000;
            ev[`APS_ST_DONE] = 1'b1;
          end else if (!strobe_ph_ff) begin
            nxt_print = {1'b1, 1'b1, cur_char};
            nxt_strobe_ph = 1'b1;
          end else begin
            nxt_print = {1'b1, 1'b0, o_print[7:0]};
            nxt_strobe_ph = 1'b0;
            if (idx_ff == last_idx) begin
              nxt_state = ST_HOLD;
              nxt_print = 10'h000;
              ev[`APS_ST_DONE] = 1'b1;
            end else begin
              nxt_idx = idx_ff + 4'h1;
            end
          end
        end
      end
      ST_HOLD: begin
        nxt_print = 10'h000;
        if (!drive)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // sequencer registers; st_hold keeps a finished string from rerunning
  // until drive has been dropped, so a new start needs drive low first
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      state_ff <= ST_IDLE;
      idx_ff <= 4'h0;
      o_print <= 10'h000;
      strobe_ph_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      o_print <= nxt_print;
      strobe_ph_ff <= (nxt_state == ST_SEND) ? nxt_strobe_ph : 1'b0;
    end
  end

  // ==========================================
  // sticky status, write one to clear, set wins
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      stat_ff <= 3'h0;
    end else begin
      if (wr_en && i_paddr == `APS_OFF_STAT)
        stat_ff <= (stat_ff & ~i_pwdata[2:0]) | ev |
                   {2'h0, 1'b0} | {1'b0, ctrl_ff[`APS_CTRL_PACKGO], 1'b0};
      else
        stat_ff <= stat_ff | ev | {1'b0, ctrl_ff[`APS_CTRL_PACKGO], 1'b0};
    end
  end
endmodule
`default_nettype wire

// file: verif/aps_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.vh"
// ========
// port checker for the print sequencer
module aps_props (
  input wire i_mclk,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_irq,
  input wire [9:0] o_print
);
  wire wr = i_psel && i_penable && i_pwrite && o_pready;
  reg [3:0] ctrl_ff;
  reg mask_ff;
  // shadow of the last control and mask writes
  always @(posedge i_mclk) begin
    if (!i_rst_b) begin
      ctrl_ff <= 4'h0;
      mask_ff <= 1'b0;
    end else if (wr && i_paddr == `APS_OFF_CTRL) begin
      ctrl_ff <= i_pwdata[3:0];
    end else if (wr && i_paddr == `APS_OFF_MASK) begin
      mask_ff <= i_pwdata[0];
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  a_strobe_busy: assert property (o_print[8] |-> o_print[9])
    else $error("strobe without busy");
  a_idle_zero: assert property (!o_print[9] |-> o_print[8:0] == 9'h000)
    else $error("idle outputs not off");
  a_busy_starts: assert property ($rose(o_print[9]) |-> o_print[8])
    else $error("busy rose without strobe");
  a_data_stable: assert property (o_print[8] ##1 o_print[8] |-> $stable(o_print[7:0]))
    else $error("data moved under strobe");
  a_null_unsent: assert property (o_print[8] && ctrl_ff[2] |-> o_print[7:0] != 8'h00)
    else $error("zero byte sent");
  a_abort_off: assert property (wr && i_paddr == `APS_OFF_CTRL && i_pwdata[2:0] == 3'h0
    && !ctrl_ff[2] |-> ##[1:2] o_print == 10'h000) else $error("abort left outputs on");
  a_done_irq: assert property ($fell(o_print[9]) && ctrl_ff[0] && mask_ff |-> ##[0:2] o_irq)
    else $error("no interrupt at completion");
  a_mask_quiet: assert property (wr && i_paddr == `APS_OFF_MASK && i_pwdata[2:0] == 3'h0
    |=> !o_irq) else $error("masked interrupt high");
  c_end16: cover property ($fell(o_print[9]) && ctrl_ff[2]);
  c_strobe: cover property ($rose(o_print[8]));
  c_irq: cover property (o_irq);
endmodule
bind aps_top aps_props u_props (.i_mclk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_irq, .o_print);
`default_nettype wire

// file: verif/aps_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// printer side: latches each character on the strobe
module aps_rx_model (
  input wire i_mclk,
  input wire [9:0] i_print
);
  logic [7:0] got[$];
  logic [9:0] prev_ff = 10'h000;
  integer ends = 0;
  // strobe rise takes data, busy fall ends a string
  always @(posedge i_mclk) begin
    if (i_print[8] && !prev_ff[8]) got.push_back(i_print[7:0]);
    if (!i_print[9] && prev_ff[9]) ends++;
    prev_ff <= i_print;
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aps_regs.vh"
// ========
// bench for the print sequencer
module tb_top;
  logic i_mclk = 0, i_rst_b = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, o_irq;
  logic [9:0] o_print;
  integer seed = 93280, miscompares = 0, check_count = 0, cyc = 0, k, i;
  logic [7:0] txt[16];
  logic [7:0] exp_q[$];
  aps_top uut (.i_mclk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .o_irq, .o_print);
  aps_rx_model rx (.i_mclk, .i_print(o_print));
  initial forever #10 i_mclk = ~i_mclk;
  // hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      give_verdict;
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    rd = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task cmp_q;
    @(posedge i_mclk);
    chk("ends", rx.ends, 1);
    rx.ends = 0;
    chk("count", rx.got.size(), exp_q.size());
    foreach (exp_q[j]) chk("char", rx.got[j], exp_q[j]);
    rx.got.delete();
  endtask
  task run_print(input logic [31:0] c);
    apb(1'b1, `APS_OFF_CTRL, c);
    while (o_print[9] !== 1'b1) @(posedge i_mclk);
    while (o_print[9] !== 1'b0) @(posedge i_mclk);
  endtask
  task load_src(input integer n);
    exp_q.delete();
    for (i = 0; i < 8; i++) apb(1'b1, `APS_OFF_SRC + 4 * i, {txt[2*i+1], txt[2*i]});
    for (i = 0; i < n; i++) exp_q.push_back(txt[i]);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rdc("ctrl", `APS_OFF_CTRL, `APS_CTRL_RST);
    rdc("scan", `APS_OFF_SCAN, `APS_SCAN_RST);
    rdc("unmapped", 12'h0fc, 32'h0);
    chk("slverr", o_pslverr, 1'b0);
    for (i = 0; i < 16; i++) txt[i] = 8'h41 + $unsigned($random(seed)) % 26;
    apb(1'b1, `APS_OFF_TEXT0, {txt[3], txt[2], txt[1], txt[0]});
    apb(1'b1, `APS_OFF_TEXT1, {txt[7], txt[6], txt[5], txt[4]});
    for (k = 0; k < 2; k++) begin
      apb(1'b1, `APS_OFF_CTRL, k * 2 + 8);
      do apb(1'b0, `APS_OFF_STAT, 32'h0); while (rd[1] !== 1'b1);
      for (i = 0; i < 4 + 4 * k; i++) rdc("dst", `APS_OFF_DST + 4 * i,
        k ? {24'h0, txt[i]} : {16'h0, txt[2*i+1], txt[2*i]});
      apb(1'b1, `APS_OFF_STAT, 32'h7);
    end
    $display("test pack done");
    load_src(8);
    apb(1'b1, `APS_OFF_SCAN, 32'h4);
    apb(1'b1, `APS_OFF_MASK, 32'h1);
    run_print(32'h1);
    cmp_q;
    rdc("stat", `APS_OFF_STAT, 32'h1);
    chk("irq", o_irq, 1'b1);
    apb(1'b1, `APS_OFF_STAT, 32'h1);
    @(posedge i_mclk);
    chk("irq", o_irq, 1'b0);
    $display("test print8 done");
    apb(1'b1, `APS_OFF_CTRL, 32'h0);
    apb(1'b1, `APS_OFF_CTRL, 32'h1);
    while (rx.got.size() < 3) @(posedge i_mclk);
    apb(1'b1, `APS_OFF_CTRL, 32'h0);
    repeat (2) @(posedge i_mclk);
    chk("print", o_print, 10'h000);
    rdc("stat", `APS_OFF_STAT, 32'h4);
    apb(1'b1, `APS_OFF_STAT, 32'h7);
    rx.got.delete();
    rx.ends = 0;
    run_print(32'h1);
    cmp_q;
    $display("test abort done");
    k = 5 + $unsigned($random(seed)) % 12;
    if (k < 16) txt[k] = 8'h00;
    load_src(k);
    apb(1'b1, `APS_OFF_CTRL, 32'h0);
    apb(1'b1, `APS_OFF_STAT, 32'h7);
    rx.got.delete();
    apb(1'b1, `APS_OFF_CTRL, 32'h5);
    while (rx.got.size() < 2) @(posedge i_mclk);
    apb(1'b1, `APS_OFF_CTRL, 32'h4);
    while (o_print[9] !== 1'b0) @(posedge i_mclk);
    cmp_q;
    rdc("stat", `APS_OFF_STAT, 32'h1);
    chk("irq", o_irq, 1'b1);
    apb(1'b1, `APS_OFF_MASK, 32'h0);
    @(posedge i_mclk);
    chk("irq", o_irq, 1'b0);
    $display("test print16 done");
    give_verdict;
  end
endmodule
`default_nettype wire
